// ### oc2_consts.svh
`ifndef OC2_CONSTS_SVH
`define OC2_CONSTS_SVH

// ============================================================
// Register offsets.
`define OC2_ADDR_DIV_LO 8'h21
`define OC2_ADDR_DIV_HI 8'h22
`define OC2_ADDR_PH_LO 8'h23
`define OC2_ADDR_PH_HI 8'h24
`define OC2_ADDR_DRV 8'h25
`define OC2_ADDR_SE 8'h26

// ============================================================
// Reset values and writable-bit masks.
`define OC2_RST_ZERO 8'h00
`define OC2_RST_DRV 8'h14
`define OC2_MASK_DIV_HI 8'h03
`define OC2_MASK_PH_HI 8'h07
`define OC2_MASK_DRV 8'hFE
`define OC2_MASK_SE 8'hFC

// ============================================================
// Field positions.
`define OC2_DRV_PD 7
`define OC2_DRV_SYNC 6
`define OC2_DRV_POL 5:4
`define OC2_DRV_STD 3:1
`define OC2_SE_PEN 7
`define OC2_SE_PPOL 6:5
`define OC2_SE_NEN 4
`define OC2_SE_NPOL 3:2

`endif

// ### oc2_pkg.sv
`default_nettype none
package oc2_pkg;
  typedef logic [9:0] oc2_div_t;
  typedef logic [10:0] oc2_phase_t;
  typedef enum logic [1:0] {
    OC2_ST_OFF = 2'b00,
    OC2_ST_WAIT = 2'b01,
    OC2_ST_RUN = 2'b10
  } oc2_state_t;

  // Polarity codes: 00 high, 01 pass, 10 invert, 11 low.
  function automatic logic oc2_apply_pol(input logic [1:0] pol, input logic lvl);
    case (pol)
      2'b00: oc2_apply_pol = 1'b1;
      2'b01: oc2_apply_pol = lvl;
      2'b10: oc2_apply_pol = ~lvl;
      default: oc2_apply_pol = 1'b0;
    endcase
  endfunction : oc2_apply_pol
endpackage : oc2_pkg
`default_nettype wire

// ### oc2_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface oc2_cfg_if;
  import oc2_pkg::*;
  oc2_div_t div_value;
  oc2_phase_t phase_offset;
  logic powerdown;
  logic sync_exclude;
  logic [1:0] diff_polarity;
  logic [2:0] driver_standard;
  logic pos_en;
  logic [1:0] pos_pol;
  logic neg_en;
  logic [1:0] neg_pol;
  modport bank (output div_value, phase_offset, powerdown, sync_exclude, diff_polarity,
    driver_standard, pos_en, pos_pol, neg_en, neg_pol);
  modport core (input div_value, phase_offset, powerdown, sync_exclude, diff_polarity,
    driver_standard, pos_en, pos_pol, neg_en, neg_pol);
endinterface : oc2_cfg_if
`default_nettype wire

// ### oc2_regbank.sv
`timescale 1ns/100ps
`default_nettype none
`include "oc2_consts.svh"
module oc2_regbank (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  oc2_cfg_if.bank cfg
);
  import oc2_pkg::*;

  logic [7:0] div_lo_reg, div_lo_next, div_hi_reg, div_hi_next;
  logic [7:0] ph_lo_reg, ph_lo_next, ph_hi_reg, ph_hi_next;
  logic [7:0] drv_reg, drv_next, se_reg, se_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg;

  // Reserved bits are never stored, so they always read back as zero.
  always_comb begin
    div_lo_next = div_lo_reg;
    div_hi_next = div_hi_reg;
    ph_lo_next = ph_lo_reg;
    ph_hi_next = ph_hi_reg;
    drv_next = drv_reg;
    se_next = se_reg;
    if (reg_wr) begin
      case (reg_addr)
        `OC2_ADDR_DIV_LO: div_lo_next = reg_wdata;
        `OC2_ADDR_DIV_HI: div_hi_next = reg_wdata & `OC2_MASK_DIV_HI;
        `OC2_ADDR_PH_LO: ph_lo_next = reg_wdata;
        `OC2_ADDR_PH_HI: ph_hi_next = reg_wdata & `OC2_MASK_PH_HI;
        `OC2_ADDR_DRV: drv_next = reg_wdata & `OC2_MASK_DRV;
        `OC2_ADDR_SE: se_next = reg_wdata & `OC2_MASK_SE;
        default: ;
      endcase
    end
    case (reg_addr)
      `OC2_ADDR_DIV_LO: rdata_next = div_lo_reg;
      `OC2_ADDR_DIV_HI: rdata_next = div_hi_reg;
      `OC2_ADDR_PH_LO: rdata_next = ph_lo_reg;
      `OC2_ADDR_PH_HI: rdata_next = ph_hi_reg;
      `OC2_ADDR_DRV: rdata_next = drv_reg;
      `OC2_ADDR_SE: rdata_next = se_reg;
      default: rdata_next = `OC2_RST_ZERO;
    endcase
    if (!reg_rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_lo_reg <= `OC2_RST_ZERO;
      div_hi_reg <= `OC2_RST_ZERO;
      ph_lo_reg <= `OC2_RST_ZERO;
      ph_hi_reg <= `OC2_RST_ZERO;
      drv_reg <= `OC2_RST_DRV;
      se_reg <= `OC2_RST_ZERO;
      rdata_reg <= `OC2_RST_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
      ph_lo_reg <= ph_lo_next;
      ph_hi_reg <= ph_hi_next;
      drv_reg <= drv_next;
      se_reg <= se_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= reg_rd;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign cfg.div_value = {div_hi_reg[1:0], div_lo_reg};
  assign cfg.phase_offset = {ph_hi_reg[2:0], ph_lo_reg};
  assign cfg.powerdown = drv_reg[`OC2_DRV_PD];
  assign cfg.sync_exclude = drv_reg[`OC2_DRV_SYNC];
  assign cfg.diff_polarity = drv_reg[`OC2_DRV_POL];
  assign cfg.driver_standard = drv_reg[`OC2_DRV_STD];
  assign cfg.pos_en = se_reg[`OC2_SE_PEN];
  assign cfg.pos_pol = se_reg[`OC2_SE_PPOL];
  assign cfg.neg_en = se_reg[`OC2_SE_NEN];
  assign cfg.neg_pol = se_reg[`OC2_SE_NPOL];
endmodule : oc2_regbank
`default_nettype wire

// ### oc2_divider.sv
`timescale 1ns/100ps
`default_nettype none
module oc2_divider (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire oc2_pkg::oc2_div_t div_value,
  output logic level,
  output logic wrap
);
  import oc2_pkg::*;

  oc2_div_t cnt_reg, cnt_next, half;
  logic level_reg, level_next;

  // Odd ratios get the longer half high; a stopped divider rests low.
  always_comb begin
    half = (div_value >> 1) + 10'h001;
    cnt_next = 10'h000;
    level_next = 1'b0;
    if (run) begin
      level_next = (cnt_reg < half);
      cnt_next = (cnt_reg >= div_value) ? 10'h000 : cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 10'h000;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
  assign wrap = run && (cnt_reg >= div_value);
endmodule : oc2_divider
`default_nettype wire

// ### oc2_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "oc2_consts.svh"
module oc2_channel (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sync_in,
  output logic diff_out,
  output logic diff_oe_n,
  output logic [2:0] driver_standard,
  output logic pos_leg_out,
  output logic pos_leg_oe_n,
  output logic neg_leg_out,
  output logic neg_leg_oe_n,
  output logic ch2_running
);
  import oc2_pkg::*;

  // ============================================================
  // Configuration registers.
  oc2_cfg_if cfg ();

  oc2_regbank u_regbank (
    .mclk(mclk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .cfg(cfg.bank)
  );

  // ============================================================
  // Sync and phase sequencing.
  // The sync request comes from the device's own sync logic on mclk, so it
  // is used without a synchroniser.
  oc2_state_t state_reg, state_next;
  oc2_div_t dly_reg, dly_next;
  oc2_div_t whole_delay;
  logic sync_hit;
  logic run;

  always_comb begin
    whole_delay = cfg.phase_offset[10:1];
    sync_hit = sync_in && !cfg.sync_exclude;
    state_next = state_reg;
    dly_next = dly_reg;
    if (cfg.powerdown) begin
      state_next = OC2_ST_OFF;
    end else begin
      case (state_reg)
        OC2_ST_OFF: begin
          state_next = OC2_ST_WAIT;
          dly_next = whole_delay;
        end
        OC2_ST_WAIT: begin
          if (sync_hit) begin
            dly_next = whole_delay;
          end else if (dly_reg == 10'h000) begin
            state_next = OC2_ST_RUN;
          end else begin
            dly_next = dly_reg - 10'h001;
          end
        end
        OC2_ST_RUN: begin
          if (sync_hit) begin
            state_next = OC2_ST_WAIT;
            dly_next = whole_delay;
          end
        end
        default: state_next = OC2_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= OC2_ST_OFF;
      dly_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      dly_reg <= dly_next;
    end
  end

  assign run = (state_reg == OC2_ST_RUN);

  // ============================================================
  // Divider and half-period retiming.
  logic div_level;
  logic div_wrap;
  logic neg_level_reg;
  logic chan_level;

  oc2_divider u_divider (
    .mclk(mclk),
    .nrst(nrst),
    .run(run),
    .div_value(cfg.div_value),
    .level(div_level),
    .wrap(div_wrap)
  );

  // A falling-edge copy supplies the odd half period of the phase offset.
  always_ff @(negedge mclk or negedge nrst) begin
    if (!nrst) begin
      neg_level_reg <= 1'b0;
    end else begin
      neg_level_reg <= div_level;
    end
  end

  // Divide by one cannot come from a flop, so the input clock is passed
  // through while running; this path is glitch-prone when run changes.
  always_comb begin
    if (cfg.div_value == 10'h000) begin
      chan_level = run && (cfg.phase_offset[0] ? ~mclk : mclk);
    end else begin
      chan_level = cfg.phase_offset[0] ? neg_level_reg : div_level;
    end
  end

  // ============================================================
  // Output drivers.
  always_comb begin
    diff_out = oc2_apply_pol(cfg.diff_polarity, chan_level);
    diff_oe_n = (cfg.driver_standard[2:1] == 2'b11);
    driver_standard = cfg.driver_standard;
    pos_leg_out = oc2_apply_pol(cfg.pos_pol, chan_level);
    pos_leg_oe_n = ~cfg.pos_en;
    neg_leg_out = oc2_apply_pol(cfg.neg_pol, chan_level);
    neg_leg_oe_n = ~cfg.neg_en;
    ch2_running = run;
  end

  // ============================================================
  // Checks.
  // Helper: cycles since the last divider wrap, valid only while the
  // configuration stayed untouched for a whole period.
  oc2_div_t gap_reg, gap_next;
  logic seen_reg, seen_next;

  always_comb begin
    gap_next = 10'h000;
    seen_next = 1'b0;
    if (run && !reg_wr) begin
      gap_next = div_wrap ? 10'h000 : gap_reg + 10'h001;
      seen_next = seen_reg | div_wrap;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 10'h000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      seen_reg <= seen_next;
    end
  end

  a_div_ratio_period: assert property (
    @(posedge mclk) disable iff (!nrst)
    (div_wrap && seen_reg && !reg_wr) |-> (gap_reg == cfg.div_value))
    else $error("divider period differs from divide value plus one");

  a_div_high_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_DIV_HI) |=>
      (cfg.div_value[9:8] == $past(reg_wdata[1:0])))
    else $error("divide value high bits not taken from written byte");

  a_phase_high_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_PH_HI) |=>
      (cfg.phase_offset[10:8] == $past(reg_wdata[2:0])))
    else $error("phase value high bits not taken from written byte");

  a_phase_delay_count: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_reg == OC2_ST_WAIT && !sync_hit && !cfg.powerdown && dly_reg != 10'h000)
      |=> (state_reg == OC2_ST_WAIT && dly_reg == $past(dly_reg) - 10'h001))
    else $error("phase delay did not count down by one");

  a_phase_zero_start: assert property (
    @(posedge mclk) disable iff (!nrst)
    (state_reg == OC2_ST_WAIT && !sync_hit && !cfg.powerdown && dly_reg == 10'h000)
      |=> run)
    else $error("channel did not start after phase delay");

  a_sync_restart: assert property (
    @(posedge mclk) disable iff (!nrst)
    (run && sync_in && !cfg.sync_exclude && !cfg.powerdown) |=>
      (state_reg == OC2_ST_WAIT && dly_reg == $past(cfg.phase_offset[10:1])))
    else $error("unmasked sync did not restart the divider");

  a_sync_masked_run: assert property (
    @(posedge mclk) disable iff (!nrst)
    (run && cfg.sync_exclude && !cfg.powerdown) |=> run)
    else $error("masked sync disturbed the divider");

  a_diff_force_level: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cfg.diff_polarity == 2'b00 |-> diff_out) and
    (cfg.diff_polarity == 2'b11 |-> !diff_out))
    else $error("differential force level wrong");

  a_driver_hiz_mode: assert property (
    @(posedge mclk) disable iff (!nrst)
    diff_oe_n == (driver_standard[2] && driver_standard[1]))
    else $error("differential enable does not follow standard code");

  a_pos_leg_drive: assert property (
    @(posedge mclk) disable iff (!nrst)
    (pos_leg_oe_n == !cfg.pos_en) and
    (cfg.pos_pol == 2'b10 |-> pos_leg_out == !diff_out || cfg.diff_polarity != 2'b01))
    else $error("positive leg enable or polarity wrong");

  a_neg_leg_drive: assert property (
    @(posedge mclk) disable iff (!nrst)
    (neg_leg_oe_n == !cfg.neg_en) and
    (cfg.neg_pol == 2'b00 |-> neg_leg_out))
    else $error("negative leg enable or polarity wrong");

  // The last running cycle still loads one divider level, so the hold is judged after four.
  a_pd_static_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    cfg.powerdown [*4] |-> (!run && !div_level && $stable(chan_level)))
    else $error("powered-down divider still toggles");

  a_pd_stops_run: assert property (
    @(posedge mclk) disable iff (!nrst)
    cfg.powerdown |=> !run)
    else $error("powered-down channel kept running");

  // Register fields must reach the channel one cycle after the write strobe.
  a_div_low_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_DIV_LO) |=>
      (cfg.div_value[7:0] == $past(reg_wdata)))
    else $error("divide value low byte not taken from written byte");

  a_phase_low_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_PH_LO) |=>
      (cfg.phase_offset[7:0] == $past(reg_wdata)))
    else $error("phase value low byte not taken from written byte");

  a_sync_mask_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_DRV) |=>
      (cfg.sync_exclude == $past(reg_wdata[`OC2_DRV_SYNC])))
    else $error("sync exclude bit not taken from written byte");

  a_diff_pass_invert: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cfg.diff_polarity == 2'b01 |-> diff_out == chan_level) and
    (cfg.diff_polarity == 2'b10 |-> diff_out == !chan_level))
    else $error("differential pass or invert wrong");

  a_std_code_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_DRV) |=>
      (driver_standard == $past(reg_wdata[`OC2_DRV_STD])))
    else $error("driver standard code not taken from written byte");

  a_leg_enable_join: assert property (
    @(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == `OC2_ADDR_SE) |=>
      (cfg.pos_en == $past(reg_wdata[`OC2_SE_PEN]) && cfg.neg_en == $past(reg_wdata[`OC2_SE_NEN])))
    else $error("leg enable bits not taken from written byte");

  a_pos_force_level: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cfg.pos_pol == 2'b00 |-> pos_leg_out) and
    (cfg.pos_pol == 2'b11 |-> !pos_leg_out))
    else $error("positive leg force level wrong");

  a_neg_low_pass: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cfg.neg_pol == 2'b11 |-> !neg_leg_out) and
    (cfg.neg_pol == 2'b01 |-> neg_leg_out == chan_level))
    else $error("negative leg force low or pass wrong");

endmodule : oc2_channel
`default_nettype wire

// ### oc2_sink_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Downstream clocked device: measures the period and high time of the
// channel clock. Sampling is on the falling edge because the channel
// output changes on the rising edge, except at divide by one or with an odd phase offset.
module oc2_sink_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_in,
  output int period,
  output int high_cnt
);
  int cnt;
  int hc;
  logic last;

  always @(negedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      hc <= 0;
      last <= 1'b0;
      period <= 0;
      high_cnt <= 0;
    end else begin
      last <= clk_in;
      if (clk_in && !last) begin
        period <= cnt;
        cnt <= 1;
        hc <= 1;
      end else begin
        cnt <= cnt + 1;
        if (clk_in) begin
          hc <= hc + 1;
        end
      end
      if (!clk_in && last) begin
        high_cnt <= hc;
      end
    end
  end
endmodule : oc2_sink_model
`default_nettype wire

// ### oc2_channel_tb.sv
`timescale 1ns/100ps
`default_nettype none
module oc2_channel_tb;
  logic mclk, nrst, reg_wr, reg_rd, sync_in, reg_rvalid, diff_out, diff_oe_n;
  logic pos_leg_out, pos_leg_oe_n, neg_leg_out, neg_leg_oe_n, ch2_running;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [2:0] driver_standard;
  int num_errors, comparisons, period, high_cnt;

  oc2_channel dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sync_in(sync_in), .diff_out(diff_out), .diff_oe_n(diff_oe_n),
    .driver_standard(driver_standard), .pos_leg_out(pos_leg_out),
    .pos_leg_oe_n(pos_leg_oe_n), .neg_leg_out(neg_leg_out), .neg_leg_oe_n(neg_leg_oe_n),
    .ch2_running(ch2_running));
  oc2_sink_model sink (.mclk(mclk), .nrst(nrst), .clk_in(diff_out), .period(period),
    .high_cnt(high_cnt));

  // ============================================================
  // Shared tasks.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    rd = 8'hEE;
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      reg_rd = 1'b0;
      if (reg_rvalid === 1'b1) begin
        rd = reg_rdata;
        break;
      end
    end
  endtask : rdr

  task automatic sync_pulse();
    @(negedge mclk);
    sync_in = 1'b1;
    @(negedge mclk);
    sync_in = 1'b0;
  endtask : sync_pulse

  // ============================================================
  // Scenarios.
  task automatic t_reset();
    logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00};
    check("diff_oe_n", 16'h0, diff_oe_n);
    check("standard", 16'h2, driver_standard);
    check("pos_oe_n", 16'h1, pos_leg_oe_n);
    check("neg_oe_n", 16'h1, neg_leg_oe_n);
    check("pos_out", 16'h1, pos_leg_out);
    check("neg_out", 16'h1, neg_leg_out);
    for (int i = 0; i < 6; i++) begin
      rdr(8'h21 + 8'(i));
      check("reset value", 16'(exp[i]), 16'(rd));
    end
    wr(8'h27, 8'hFF);
    rdr(8'h27);
    check("unmapped", 16'h0, 16'(rd));
  endtask : t_reset

  task automatic t_reserved();
    wr(8'h22, 8'hFF);
    rdr(8'h22);
    check("div hi bits", 16'h03, 16'(rd));
    wr(8'h24, 8'hFF);
    rdr(8'h24);
    check("phase hi bits", 16'h07, 16'(rd));
    wr(8'h26, 8'hFF);
    rdr(8'h26);
    check("se bits", 16'h0FC, 16'(rd));
    wr(8'h26, 8'h00);
    wr(8'h24, 8'h00);
  endtask : t_reserved

  task automatic t_divide(input logic [9:0] d);
    wr(8'h21, d[7:0]);
    wr(8'h22, {6'h00, d[9:8]});
    sync_pulse();
    repeat (3 * (int'(d) + 1) + 20) @(negedge mclk);
    check("period", 16'(d) + 16'h1, 16'(period));
    check("high time", 16'(d >> 1) + 16'h1, 16'(high_cnt));
  endtask : t_divide

  // Odd offsets move the output on the falling edge, so the delay is counted in
  // half periods, each sampled 1 ns after its edge once the output has settled.
  task automatic t_phase(input logic [10:0] p);
    int h;
    wr(8'h23, p[7:0]);
    wr(8'h24, {5'h00, p[10:8]});
    @(negedge mclk);
    sync_in = 1'b1;
    @(negedge mclk);
    sync_in = 1'b0;
    check("restarted", 16'h0, ch2_running);
    h = 0;
    do begin
      @(mclk);
      #1;
      h++;
      if (h == 3) begin
        check("held low", 16'h0, diff_out);
      end
    end while ((h < 3 || diff_out !== 1'b1) && h < 2200);
    check("phase delay", 16'(p) + 16'h3, 16'(h));
  endtask : t_phase

  // Divide by one passes the input clock, so it is sampled just after each edge.
  task automatic t_bypass();
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h00);
    sync_pulse();
    repeat (4) @(negedge mclk);
    @(posedge mclk);
    #1;
    check("bypass high", 16'h1, diff_out);
    @(negedge mclk);
    #1;
    check("bypass low", 16'h0, diff_out);
    check("bypass run", 16'h1, ch2_running);
  endtask : t_bypass

  task automatic t_exclude();
    wr(8'h25, 8'h54);
    sync_pulse();
    repeat (2) begin
      @(negedge mclk);
      check("excluded", 16'h1, ch2_running);
    end
    repeat (12) @(negedge mclk);
    check("period kept", 16'h4, 16'(period));
    wr(8'h25, 8'h14);
  endtask : t_exclude

  // With the divider stopped its level is low, so every code's output is known.
  task automatic t_codes();
    for (int k = 0; k < 8; k++) begin
      wr(8'h25, 8'h80 | 8'((k % 4) << 4) | 8'(k << 1));
      repeat (3) @(negedge mclk);
      check("stopped", 16'h0, ch2_running);
      check("diff pol", 16'(k % 2 == 0), diff_out);
      check("standard", 16'(k), driver_standard);
      check("diff_oe_n", 16'(k >= 6), diff_oe_n);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h26, 8'((k % 2) << 7 | k << 5 | (k % 2) << 4 | (3 - k) << 2));
      repeat (2) @(negedge mclk);
      check("pos_out", 16'(k % 2 == 0), pos_leg_out);
      check("neg_out", 16'((3 - k) % 2 == 0), neg_leg_out);
      check("pos_oe_n", 16'(k % 2 == 0), pos_leg_oe_n);
      check("neg_oe_n", 16'(k % 2 == 0), neg_leg_oe_n);
    end
    wr(8'h25, 8'h14);
    repeat (40) @(negedge mclk);
    check("resumed", 16'h4, 16'(period));
  endtask : t_codes

  // ============================================================
  // Clock, reset, sequence and watchdog.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #500000;
    num_errors++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sync_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_reserved();
    t_bypass();
    t_divide(10'h001);
    t_divide(10'h3FF);
    t_divide(10'h101);
    t_divide(10'h003);
    t_phase(11'h001);
    t_phase(11'h7FE);
    t_phase(11'h004);
    t_exclude();
    t_codes();
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    complete_run();
  end
endmodule : oc2_channel_tb
`default_nettype wire
